// ===== logic/spil_pkg.sv
// shared constants for the switch port interrupt logic
package spil_pkg;
  // register map: word 0 upstream state, then one 16-byte block per downstream port
  localparam logic [11:0] UP_STATE_OFS = 12'h000;
  localparam int          PORT_SEL_LSB = 4;
  localparam logic [1:0]  REG_CTRL     = 2'h0;
  localparam logic [1:0]  REG_STAT     = 2'h1;
  localparam logic [1:0]  REG_ALO      = 2'h2;
  localparam logic [1:0]  REG_AHI      = 2'h3;
  // control fields
  localparam int CTRL_MSI_EN  = 0;
  localparam int CTRL_LEG_DIS = 1;
  localparam int CTRL_HP_IE   = 2;
  localparam int CTRL_BW_IE   = 3;
  localparam int CTRL_ABW_IE  = 4;
  localparam int CTRL_W       = 5;
  localparam logic [4:0] CTRL_RST = 5'h00;
  // status fields
  localparam int STS_HP   = 0;
  localparam int STS_BW   = 1;
  localparam int STS_ABW  = 2;
  localparam int STS_W    = 3;
  localparam int STS_LINK = 8;
  localparam int STS_VW   = 12;
  localparam logic [2:0] STS_RST = 3'h0;
  // upstream state word fields
  localparam int UPS_AGG  = 0;
  localparam int UPS_SENT = 4;
  // virtual wires a..d
  localparam int NWIRE = 4;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
endpackage

// ===== logic/spil_port_if.sv
// signals between the register file and one downstream port engine
`timescale 1ns/100ps
interface spil_port_if;
  logic [4:0] ctrl;
  logic [2:0] sts;
  logic       link_up;
  logic [3:0] ext_intx;
  logic       msi_ack;
  logic       msi_pend;
  logic [3:0] vwire;

  modport port (
    input  ctrl,
    input  sts,
    input  link_up,
    input  ext_intx,
    input  msi_ack,
    output msi_pend,
    output vwire
  );
  modport regs (
    output ctrl,
    output sts,
    output link_up,
    output ext_intx,
    output msi_ack,
    input  msi_pend,
    input  vwire
  );
endinterface

// ===== logic/spil_port.sv
// per downstream port msi / inta generation
`timescale 1ns/100ps
module spil_port (
  input  wire logic pclk,
  input  wire logic presetn,
  spil_port_if.port bus
);
  typedef struct packed {
    logic cond;
    logic inta;
    logic msi_pend;
  } spil_port_st_t;

  spil_port_st_t st_reg;
  spil_port_st_t st_next;
  logic          cond_c;
  logic          msi_en;
  logic          dis;

  assign msi_en = bus.ctrl[spil_pkg::CTRL_MSI_EN];
  assign dis    = bus.ctrl[spil_pkg::CTRL_LEG_DIS];

  // bandwidth bits count only while their notification is enabled
  assign cond_c = (bus.sts[spil_pkg::STS_HP] & bus.ctrl[spil_pkg::CTRL_HP_IE])
                | (bus.sts[spil_pkg::STS_BW] & bus.ctrl[spil_pkg::CTRL_BW_IE])
                | (bus.sts[spil_pkg::STS_ABW] & bus.ctrl[spil_pkg::CTRL_ABW_IE]);

  // edge detect on the masked condition
  always_comb
  begin
    st_next = st_reg;
    st_next.cond = cond_c;
    if (bus.msi_ack)
    begin
      st_next.msi_pend = 1'b0;
    end
    if (cond_c && !st_reg.cond)
    begin
      if (msi_en)
      begin
        st_next.msi_pend = 1'b1;
      end
      else if (!dis)
      begin
        st_next.inta = 1'b1;
      end
    end
    else if (!cond_c && st_reg.cond && !msi_en && !dis)
    begin
      st_next.inta = 1'b0;
    end
    // link down drops the wire so it does not reassert stale on link up
    if (!bus.link_up)
    begin
      st_next.inta = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // own interrupt only on wire a, external wires pass unmapped
  assign bus.msi_pend = st_reg.msi_pend;
  assign bus.vwire    = bus.link_up ? (bus.ext_intx | {3'h0, st_reg.inta}) : 4'h0;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_msi_rise;
    $rose(cond_c) && msi_en |=> st_reg.msi_pend;
  endproperty
  a_msi_rise: assert property (p_msi_rise) else $error("msi not raised on rise");

  property p_inta_rise;
    $rose(cond_c) && !msi_en && !dis && bus.link_up |=> st_reg.inta;
  endproperty
  a_inta_rise: assert property (p_inta_rise) else $error("inta not asserted");

  property p_inta_off;
    !st_reg.inta && (msi_en || dis) |=> !st_reg.inta;
  endproperty
  a_inta_off: assert property (p_inta_off) else $error("inta set while blocked");

  property p_inta_fall;
    $fell(cond_c) && !msi_en && !dis |=> !st_reg.inta;
  endproperty
  a_inta_fall: assert property (p_inta_fall) else $error("inta not deasserted");

  property p_no_msi_neg;
    !st_reg.msi_pend && !cond_c |=> !st_reg.msi_pend;
  endproperty
  a_no_msi_neg: assert property (p_no_msi_neg) else $error("msi on negation");

  property p_down;
    !bus.link_up |-> bus.vwire == 4'h0 ##1 !st_reg.inta;
  endproperty
  a_down: assert property (p_down) else $error("wires live on link down");

  property p_only_a;
    bus.link_up && bus.ext_intx == 4'h0 |-> bus.vwire[3:1] == 3'h0;
  endproperty
  a_only_a: assert property (p_only_a) else $error("own irq on b..d");
endmodule

// ===== logic/spil_top.sv
// switch port interrupt logic: apb registers, msi arbiter, upstream intx aggregation
`timescale 1ns/100ps
module spil_top #(
  parameter int NP       = 4,
  parameter int DEV_BASE = 1
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [11:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NP-1:0]     hp_event,
  input  wire logic [NP-1:0]     bw_event,
  input  wire logic [NP-1:0]     abw_event,
  input  wire logic [NP-1:0]     link_up,
  input  wire logic [4*NP-1:0]   ext_intx,
  input  wire logic              up_own_irq,
  output logic                   msi_valid,
  output logic      [7:0]        msi_port,
  output logic      [63:0]       msi_addr,
  input  wire logic              msi_ready,
  output logic                   msg_valid,
  output logic                   msg_assert,
  output logic      [1:0]        msg_wire,
  input  wire logic              msg_ready
);
  typedef struct packed {
    logic [NP-1:0][4:0]  ctrl;
    logic [NP-1:0][2:0]  sts;
    logic [NP-1:0][31:0] alo;
    logic [NP-1:0][31:0] ahi;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                msi_valid;
    logic [7:0]          msi_port;
    logic [63:0]         msi_addr;
    logic [3:0]          sent;
    logic                msg_valid;
    logic                msg_assert;
    logic [1:0]          msg_wire;
  } spil_top_st_t;

  spil_top_st_t        st_reg;
  spil_top_st_t        st_next;
  logic [NP-1:0]       ack_c;
  logic [NP-1:0]       pend_w;
  logic [NP-1:0][3:0]  vw_w;
  logic [3:0]          up_w;
  logic                acc;
  logic                wr_go;
  logic [7:0]          psel_idx;
  logic [31:0]         rd_c;
  logic                hit_c;
  logic                picked;

  spil_port_if pif [NP] ();

  // rotate a wire group left by the device remainder
  function automatic logic [3:0] spil_rot(input logic [3:0] v, input logic [1:0] n);
    logic [7:0] d;
    d = {v, v} << n;
    return d[7:4];
  endfunction

  // one engine per downstream port
  generate
    for (genvar i = 0; i < NP; i++)
    begin : g_port
      assign pif[i].ctrl     = st_reg.ctrl[i];
      assign pif[i].sts      = st_reg.sts[i];
      assign pif[i].link_up  = link_up[i];
      assign pif[i].ext_intx = ext_intx[4*i +: 4];
      assign pif[i].msi_ack  = ack_c[i];
      assign pend_w[i]       = pif[i].msi_pend;
      assign vw_w[i]         = pif[i].vwire;
      spil_port u_port (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (pif[i].port)
      );
    end
  endgenerate

  // upstream aggregate: own irq on wire a plus every rotated port group
  always_comb
  begin
    up_w = {3'h0, up_own_irq};
    for (int i = 0; i < NP; i++)
    begin
      up_w = up_w | spil_rot(vw_w[i], 2'(i + DEV_BASE));
    end
  end

  assign acc      = psel && penable;
  // write lands only at the edge where pready is seen high
  assign wr_go    = acc && st_reg.pready && pwrite;
  assign psel_idx = paddr[11:spil_pkg::PORT_SEL_LSB];

  // read mux and decode, unmapped words give pslverr and zero data
  always_comb
  begin
    rd_c  = 32'h0;
    hit_c = 1'b0;
    if (paddr == spil_pkg::UP_STATE_OFS)
    begin
      hit_c = 1'b1;
      rd_c[spil_pkg::UPS_AGG +: 4]  = up_w;
      rd_c[spil_pkg::UPS_SENT +: 4] = st_reg.sent;
    end
    for (int i = 0; i < NP; i++)
    begin
      if (psel_idx == 8'(i + 1) && paddr[1:0] == 2'h0)
      begin
        hit_c = 1'b1;
        unique case (paddr[3:2])
          spil_pkg::REG_CTRL: rd_c[4:0] = st_reg.ctrl[i];
          spil_pkg::REG_STAT:
          begin
            rd_c[2:0]                   = st_reg.sts[i];
            rd_c[spil_pkg::STS_LINK]    = link_up[i];
            rd_c[spil_pkg::STS_VW +: 4] = vw_w[i];
          end
          spil_pkg::REG_ALO:  rd_c = st_reg.alo[i];
          spil_pkg::REG_AHI:  rd_c = st_reg.ahi[i];
        endcase
      end
    end
  end

  // next state of everything the top keeps
  always_comb
  begin
    st_next = st_reg;
    ack_c   = '0;
    picked  = 1'b0;
    // apb: one wait state, answer registered
    st_next.pready  = acc && !st_reg.pready;
    st_next.pslverr = acc && !st_reg.pready && !hit_c;
    st_next.prdata  = (acc && !st_reg.pready && !pwrite) ? rd_c : 32'h0;
    for (int i = 0; i < NP; i++)
    begin
      if (wr_go && psel_idx == 8'(i + 1) && paddr[1:0] == 2'h0)
      begin
        unique case (paddr[3:2])
          spil_pkg::REG_CTRL: st_next.ctrl[i] = pwdata[4:0];
          spil_pkg::REG_STAT: st_next.sts[i] = st_reg.sts[i] & ~pwdata[2:0];
          spil_pkg::REG_ALO:  st_next.alo[i] = pwdata;
          spil_pkg::REG_AHI:  st_next.ahi[i] = pwdata;
        endcase
      end
      // events set after the clear so a same-cycle event is kept
      if (hp_event[i])
      begin
        st_next.sts[i][spil_pkg::STS_HP] = 1'b1;
      end
      if (bw_event[i])
      begin
        st_next.sts[i][spil_pkg::STS_BW] = 1'b1;
      end
      if (abw_event[i])
      begin
        st_next.sts[i][spil_pkg::STS_ABW] = 1'b1;
      end
    end
    // msi arbiter: fixed priority, lowest port first; the message leaves
    // on the upstream egress only, the address is not decoded here
    if (st_reg.msi_valid && msi_ready)
    begin
      st_next.msi_valid = 1'b0;
    end
    if (!st_reg.msi_valid)
    begin
      for (int i = 0; i < NP; i++)
      begin
        if (pend_w[i] && !picked)
        begin
          picked            = 1'b1;
          ack_c[i]          = 1'b1;
          st_next.msi_valid = 1'b1;
          st_next.msi_port  = 8'(i);
          st_next.msi_addr  = {st_reg.ahi[i], st_reg.alo[i]};
        end
      end
    end
    // upstream messages: one per change of the sent state of a wire
    if (st_reg.msg_valid && msg_ready)
    begin
      st_next.msg_valid                 = 1'b0;
      st_next.sent[st_reg.msg_wire]     = st_reg.msg_assert;
    end
    else if (!st_reg.msg_valid)
    begin
      for (int w = spil_pkg::NWIRE - 1; w >= 0; w--)
      begin
        if (up_w[w] != st_reg.sent[w])
        begin
          st_next.msg_valid  = 1'b1;
          st_next.msg_assert = up_w[w];
          st_next.msg_wire   = 2'(w);
        end
      end
    end
  end

  // reset: masks clear, legacy enabled, no message owed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg      <= '0;
      st_reg.ctrl <= {NP{spil_pkg::CTRL_RST}};
      st_reg.sts  <= {NP{spil_pkg::STS_RST}};
      st_reg.alo  <= {NP{spil_pkg::ADDR_RST}};
      st_reg.ahi  <= {NP{spil_pkg::ADDR_RST}};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign prdata     = st_reg.prdata;
  assign pready     = st_reg.pready;
  assign pslverr    = st_reg.pslverr;
  assign msi_valid  = st_reg.msi_valid;
  assign msi_port   = st_reg.msi_port;
  assign msi_addr   = st_reg.msi_addr;
  assign msg_valid  = st_reg.msg_valid;
  assign msg_assert = st_reg.msg_assert;
  assign msg_wire   = st_reg.msg_wire;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_msg_assert;
    msg_valid && msg_assert |-> !st_reg.sent[msg_wire];
  endproperty
  a_msg_assert: assert property (p_msg_assert) else $error("assert on asserted wire");

  property p_msg_deassert;
    msg_valid && !msg_assert |-> st_reg.sent[msg_wire];
  endproperty
  a_msg_deassert: assert property (p_msg_deassert) else $error("deassert on idle wire");

  property p_sent_flip;
    msg_valid && msg_ready |=> st_reg.sent == ($past(st_reg.sent) ^ (4'h1 << $past(msg_wire)));
  endproperty
  a_sent_flip: assert property (p_sent_flip) else $error("sent state wrong");

  // an idle channel must pick up any wire whose aggregate moved
  property p_settle;
    !msg_valid && up_w != st_reg.sent |=> msg_valid;
  endproperty
  a_settle: assert property (p_settle) else $error("aggregate change not sent");

  property p_msi_hold;
    msi_valid && !msi_ready |=> msi_valid && $stable(msi_addr) && $stable(msi_port);
  endproperty
  a_msi_hold: assert property (p_msi_hold) else $error("msi dropped");

  property p_own_a;
    up_own_irq && st_reg.sent[0] == 1'b0 && !msg_valid |=> msg_valid && msg_wire == 2'h0;
  endproperty
  a_own_a: assert property (p_own_a) else $error("own irq not on wire a");

  // port 0 sits behind device DEV_BASE, so its wire a lands on wire DEV_BASE mod 4
  property p_rot0;
    vw_w[0][0] |-> up_w[2'(DEV_BASE)];
  endproperty
  a_rot0: assert property (p_rot0) else $error("port 0 wire a not rotated");

  property p_msg_hold;
    msg_valid && !msg_ready |=> msg_valid && $stable(msg_wire) && $stable(msg_assert);
  endproperty
  a_msg_hold: assert property (p_msg_hold) else $error("message dropped");

  property p_hp_set;
    hp_event[0] |=> st_reg.sts[0][spil_pkg::STS_HP];
  endproperty
  a_hp_set: assert property (p_hp_set) else $error("hot-plug event lost");

  property p_pready;
    pready |=> !pready;
  endproperty
  a_pready: assert property (p_pready) else $error("pready held");
endmodule

// ===== tb/spil_root_model.sv
// behavioural upstream partner: takes msi writes and intx messages
`timescale 1ns/100ps
module spil_root_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        slow,
  input  wire logic        msi_valid,
  input  wire logic [7:0]  msi_port,
  input  wire logic [63:0] msi_addr,
  output logic             msi_ready,
  input  wire logic        msg_valid,
  input  wire logic        msg_assert,
  input  wire logic [1:0]  msg_wire,
  output logic             msg_ready,
  output int               n_msi,
  output int               n_msg,
  output logic [71:0]      last_msi,
  output logic [2:0]       last_msg
);
  logic [1:0] age;

  // slow mode stalls two cycles so the design must hold its request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      msi_ready <= 1'b0;
      msg_ready <= 1'b0;
      age       <= 2'h0;
      n_msi     <= 0;
      n_msg     <= 0;
      last_msi  <= 72'h0;
      last_msg  <= 3'h0;
    end
    else
    begin
      if ((msi_valid || msg_valid) && age != 2'h3)
        age <= age + 2'h1;
      msi_ready <= msi_valid && !msi_ready && (!slow || age >= 2'h2);
      msg_ready <= msg_valid && !msg_ready && (!slow || age >= 2'h2);
      if (msi_valid && msi_ready)
      begin
        n_msi    <= n_msi + 1;
        last_msi <= {msi_port, msi_addr};
        age      <= 2'h0;
        msi_ready <= 1'b0;
      end
      if (msg_valid && msg_ready)
      begin
        n_msg    <= n_msg + 1;
        last_msg <= {msg_assert, msg_wire};
        age      <= 2'h0;
        msg_ready <= 1'b0;
      end
    end
  end
endmodule

// ===== tb/tb_switch_port_interrupt_logic.sv
// self-checking bench for the switch port interrupt logic
`timescale 1ns/100ps
module tb_switch_port_interrupt_logic;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
  logic [11:0] paddr, b;
  logic [31:0] pwdata, prdata;
  logic [3:0]  hp_event, bw_event, abw_event, link_up;
  logic [15:0] ext_intx;
  logic        up_own_irq, msi_valid, msi_ready, msg_valid, msg_assert, msg_ready;
  logic [7:0]  msi_port;
  logic [63:0] msi_addr;
  logic [1:0]  msg_wire;
  logic [71:0] last_msi;
  logic [2:0]  last_msg;
  int          n_msi, n_msg, seen, n_fail, n_checks;

  spil_top #(.NP(4), .DEV_BASE(1)) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hp_event(hp_event), .bw_event(bw_event),
    .abw_event(abw_event), .link_up(link_up), .ext_intx(ext_intx), .up_own_irq(up_own_irq),
    .msi_valid(msi_valid), .msi_port(msi_port), .msi_addr(msi_addr), .msi_ready(msi_ready),
    .msg_valid(msg_valid), .msg_assert(msg_assert), .msg_wire(msg_wire),
    .msg_ready(msg_ready));
  spil_root_model u_root (.pclk(pclk), .presetn(presetn), .slow(slow),
    .msi_valid(msi_valid), .msi_port(msi_port), .msi_addr(msi_addr), .msi_ready(msi_ready),
    .msg_valid(msg_valid), .msg_assert(msg_assert), .msg_wire(msg_wire),
    .msg_ready(msg_ready), .n_msi(n_msi), .n_msg(n_msg), .last_msi(last_msi),
    .last_msg(last_msg));

  // 25 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    chk("write error", 32'h0, {31'h0, e});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk("read data", exp, q);
    chk("read error", {31'h0, experr}, {31'h0, e});
  endtask

  task automatic pulse(input int k, input int p);
    @(posedge pclk);
    if (k == 0) hp_event[p] <= 1'b1;
    else if (k == 1) bw_event[p] <= 1'b1;
    else abw_event[p] <= 1'b1;
    @(posedge pclk);
    hp_event <= 4'h0; bw_event <= 4'h0; abw_event <= 4'h0;
  endtask

  // waits for the next upstream message and compares kind and wire
  task automatic expect_msg(input logic a, input logic [1:0] w);
    int n;
    n = 0;
    while (n_msg == seen && n < 60)
    begin
      @(posedge pclk);
      n++;
    end
    seen++;
    chk("msg count", seen, n_msg);
    chk("msg kind and wire", {29'h0, a, w}, {29'h0, last_msg});
  endtask

  // no new message may appear in a generous quiet span
  task automatic quiet();
    repeat (12) @(posedge pclk);
    chk("msg count", seen, n_msg);
  endtask

  // hang guard, far beyond the few hundred cycles the tests take
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    $display("BAD watchdog expected end seen hang");
    complete_run();
  end

  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; hp_event = 4'h0; bw_event = 4'h0; abw_event = 4'h0;
    link_up = 4'hf; ext_intx = 16'h0; up_own_irq = 1'b0; slow = 1'b0; seen = 0;
    n_fail = 0; n_checks = 0; b = 12'h000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, unmapped and unaligned places
    rd(12'h000, 32'h0, 1'b0);
    rd(12'h010, 32'h0, 1'b0);
    rd(12'h014, 32'h100, 1'b0);
    rd(12'h0fc, 32'h0, 1'b1);
    rd(12'h002, 32'h0, 1'b1);
    $display("test registers done");
    // msi wins even with legacy disabled; clearing sends nothing
    wr(12'h028, 32'h0000_1000);
    wr(12'h02c, 32'h0000_0001);
    wr(12'h020, 32'h0000_0007);
    pulse(0, 1);
    for (int n = 0; n < 60 && n_msi == 0; n++) @(posedge pclk);
    chk("msi count", 32'h1, n_msi);
    chk("msi port", 32'h1, {24'h0, last_msi[71:64]});
    chk("msi addr low", 32'h1000, last_msi[31:0]);
    chk("msi addr high", 32'h1, last_msi[63:32]);
    wr(12'h024, 32'h7);
    quiet();
    chk("msi count", 32'h1, n_msi);
    $display("test msi done");
    // each source, masked then unmasked, legacy path
    for (int k = 0; k < 3; k++)
    begin
      b = 12'(16 * (k + 1));
      pulse(k, k);
      quiet();
      wr(b, 32'h1 << (2 + k));
      expect_msg(1'b1, 2'(k + 1));
      rd(b + 12'h4, 32'h1100 | (32'h1 << k), 1'b0);
      rd(12'h000, 32'h11 << (k + 1), 1'b0);
      if (k == 0) wr(b, 32'h0);
      else wr(b + 12'h4, 32'h7);
      expect_msg(1'b0, 2'(k + 1));
    end
    wr(12'h014, 32'h7);
    $display("test legacy sources done");
    // legacy disabled: nothing sent
    wr(12'h010, 32'h6);
    pulse(0, 0);
    quiet();
    rd(12'h014, 32'h101, 1'b0);
    wr(12'h014, 32'h7);
    // link down negates the port wires
    pulse(2, 2);
    expect_msg(1'b1, 2'h3);
    link_up[2] <= 1'b0;
    expect_msg(1'b0, 2'h3);
    rd(12'h034, 32'h4, 1'b0);
    wr(12'h034, 32'h7);
    link_up[2] <= 1'b1;
    $display("test disable and link down done");
    // swizzle of device wires with a stalling partner
    slow <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      ext_intx[4 * i] <= 1'b1;
      expect_msg(1'b1, 2'(i + 1));
      rd(12'(16 * (i + 1) + 4), 32'h1100, 1'b0);
      ext_intx[4 * i] <= 1'b0;
      expect_msg(1'b0, 2'(i + 1));
    end
    // own interrupt and a device wire share upstream wire a
    up_own_irq <= 1'b1;
    expect_msg(1'b1, 2'h0);
    ext_intx[12] <= 1'b1;
    quiet();
    up_own_irq <= 1'b0;
    quiet();
    ext_intx[12] <= 1'b0;
    expect_msg(1'b0, 2'h0);
    $display("test aggregation done");
    complete_run();
  end
endmodule
